// File: pkg/asf_pkg.sv
// Constants shared by the serial framing block and its register map.
// Assumes a single 8-bit register space of sixteen entries.
package asf_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_DEVICE_IDENTITY = 4'h0;
  localparam logic [3:0] ADDR_DIE_REVISION = 4'h1;
  localparam logic [3:0] ADDR_STATUS_FLAGS = 4'h2;
  localparam logic [3:0] ADDR_CONVERSION_COMMAND = 4'h3;
  localparam logic [3:0] ADDR_INPUT_SELECT = 4'h4;
  localparam logic [3:0] ADDR_ANALOG_CONFIG = 4'h5;
  localparam logic [3:0] ADDR_CONVERSION_CONFIG = 4'h6;
  localparam logic [3:0] ADDR_FILTER_CONFIG = 4'h7;
  localparam logic [3:0] ADDR_INTERFACE_CONFIG = 4'h8;
  localparam logic [3:0] ADDR_OFFSET_CAL_HIGH = 4'h9;
  localparam logic [3:0] ADDR_OFFSET_CAL_MID = 4'ha;
  localparam logic [3:0] ADDR_OFFSET_CAL_LOW = 4'hb;
  localparam logic [3:0] ADDR_GAIN_CAL_HIGH = 4'hc;
  localparam logic [3:0] ADDR_GAIN_CAL_MID = 4'hd;
  localparam logic [3:0] ADDR_GAIN_CAL_LOW = 4'he;
  localparam logic [3:0] ADDR_REGISTER_MAP_CHECK = 4'hf;
  // Writes in this range restart the converter while it is converting
  localparam logic [3:0] ADDR_RESTART_FIRST = 4'h4;
  localparam logic [3:0] ADDR_RESTART_LAST = 4'he;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_GAIN_CAL_HIGH = 8'h40;
  // Identity value is arbitrary
  localparam logic [7:0] DEVICE_IDENTITY_VALUE = 8'h5a;

  // ---------------------------------------------------------------
  // Status register bit positions
  // ---------------------------------------------------------------
  localparam int ST_WIRE_COUNT = 7;
  localparam int ST_ANALOG_UV = 6;
  localparam int ST_POWER_ON = 5;
  localparam int ST_IF_CHECK_ERR = 4;
  localparam int ST_MAP_CHECK_ERR = 3;
  localparam int ST_CONV_ERR = 2;
  localparam int ST_MOD_SAT = 1;
  localparam int ST_CONV_READY = 0;

  // ---------------------------------------------------------------
  // Conversion command fields
  // ---------------------------------------------------------------
  localparam logic [5:0] DEVICE_RESET_CODE = 6'h16;
  localparam int CMD_START_BIT = 1;
  localparam int CMD_STOP_BIT = 0;

  // Interface configuration bits that lengthen the frame
  localparam int IFC_CHECK_BYTE_BIT = 2;
  localparam int IFC_STATUS_HDR_BIT = 0;

  // ---------------------------------------------------------------
  // Serial command word
  // ---------------------------------------------------------------
  localparam logic [2:0] OPC_READ = 3'h2;
  localparam logic [2:0] OPC_WRITE = 3'h4;

  // ---------------------------------------------------------------
  // Frame timing in serial clocks; strap wait in system clocks
  // ---------------------------------------------------------------
  localparam logic [5:0] FRAME_BASE_BITS = 6'h18;
  localparam logic [5:0] FRAME_BYTE_BITS = 6'h08;
  localparam logic [5:0] RESYNC_ONES = 6'h3f;
  localparam logic [1:0] STRAP_WAIT_CYCLES = 2'h3;

endpackage

// File: core/asf_sync.sv
// Two-flop synchroniser for levels entering a clock domain.
// Assumes each bit is an independent or slowly changing level.
`timescale 1ns/1ns
`default_nettype none

module asf_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= RESET_VALUE;
      q_o <= RESET_VALUE;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

`default_nettype wire

// File: core/asf_spi_framing.sv
// Serial host interface with frame counting and the register map.
// Assumes clk_i is the system clock and link_sclk_i the host shift clock.
//
// How it works
// - Chip select low at reset selects 3-wire
// - Status bit 7 shows detected wire mode
// - Chip select high forces 4-wire mode
// - 3-wire frames delimited by counting shift clocks
// - Same format, frames back to back
// - 63 ones then zero realigns frame
// - Realign touches only frame counter
// - One register access per frame
// - Writes 4h-Eh restart conversion, drop sync
// - Idle converter stays idle on such writes
// - Revision register read-only, 8-bit input
// - Status resets with both flags set
// - Wire indicator 0 four-wire, 1 three-wire
// - Undervoltage flag sticky until write one
// - Power-on flag set by resets, write one clears
// - Frame 24 bits plus optional bytes
// - Interface check error blocks writes except status
// - Reset code with start/stop zero resets
`timescale 1ns/1ns
`default_nettype none

module asf_spi_framing (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic link_sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic [7:0] die_revision_i,
  input wire logic analog_low_i,
  input wire logic io_brownout_i,
  input wire logic regulator_fault_i,
  input wire logic if_check_err_i,
  input wire logic map_check_err_i,
  input wire logic conv_err_i,
  input wire logic modulator_saturation_flag_i,
  input wire logic conversion_ready_i,
  input wire logic converting_i,
  output logic conv_start_o,
  output logic conv_stop_o,
  output logic conv_restart_o,
  output logic sync_lost_o,
  output logic device_reset_o,
  output logic [7:0] input_select_o,
  output logic [7:0] analog_config_o,
  output logic [7:0] conversion_config_o,
  output logic [7:0] filter_config_o,
  output logic [7:0] interface_config_o,
  output logic [23:0] offset_cal_o,
  output logic [23:0] gain_cal_o
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------

  // Last bit index of a frame given the optional byte enables
  function automatic logic [5:0] frame_last(input logic hdr, input logic chk);
    logic [5:0] len;
    len = asf_pkg::FRAME_BASE_BITS;
    if (hdr)
      len = len + asf_pkg::FRAME_BYTE_BITS;
    if (chk)
      len = len + asf_pkg::FRAME_BYTE_BITS;
    return len - 6'h01;
  endfunction

  // Reset value of a configuration register
  function automatic logic [7:0] cfg_reset(input logic [3:0] addr);
    return (addr == asf_pkg::ADDR_GAIN_CAL_HIGH) ? asf_pkg::RST_GAIN_CAL_HIGH
                                                 : asf_pkg::RST_CONFIG;
  endfunction

  // ---------------------------------------------------------------
  // Link domain: shift clock logic
  // ---------------------------------------------------------------
  logic link_rst_n;
  logic wire3_link;
  logic [1:0] len_sel_link;
  logic [5:0] bit_cnt_q;
  logic [5:0] bit_cnt_d;
  logic [5:0] ones_q;
  logic [5:0] ones_d;
  logic [39:0] shift_in_q;
  logic [39:0] shift_in_d;
  logic [15:0] cmd_q;
  logic done_tgl_q;
  logic [39:0] shift_out_q;
  logic [39:0] out_word;
  logic [5:0] last_bit;
  logic realign;
  logic frame_end;
  logic [7:0] snap_status_q;
  logic [7:0] snap_data_q;
  logic wire3_q;

  // Chip select high holds the shift logic idle between 4-wire frames
  assign link_rst_n = rst_n_i & ~cs_n_i;

  asf_sync #(.WIDTH(3), .RESET_VALUE(3'h0)) u_sync_link (
    .clk_i(link_sclk_i),
    .rst_n_i(rst_n_i),
    .d_i({wire3_q, interface_config_o[asf_pkg::IFC_STATUS_HDR_BIT],
          interface_config_o[asf_pkg::IFC_CHECK_BYTE_BIT]}),
    .q_o({wire3_link, len_sel_link})
  );

  // Frame length follows the enabled header and check bytes
  assign last_bit = frame_last(len_sel_link[1], len_sel_link[0]);
  // Resync pattern: 63 ones seen, then a zero
  assign realign = wire3_link & ~sdi_i & (ones_q == asf_pkg::RESYNC_ONES);
  assign frame_end = ~realign & (bit_cnt_q == last_bit);
  // Frame counter wraps at the frame length; next clock opens a frame
  assign bit_cnt_d = (realign | frame_end) ? 6'h00 : bit_cnt_q + 6'h01;
  // Ones counter saturates and restarts on any zero
  assign ones_d = ~sdi_i ? 6'h00 :
                  (ones_q == asf_pkg::RESYNC_ONES) ? ones_q : ones_q + 6'h01;
  assign shift_in_d = {shift_in_q[38:0], sdi_i};

  // Input sampling on the falling shift clock edge
  always_ff @(negedge link_sclk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bit_cnt_q <= 6'h00;
      ones_q <= 6'h00;
      shift_in_q <= 40'h0;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_d;
      ones_q <= ones_d;
      shift_in_q <= shift_in_d;
    end
  end

  // Command handoff survives chip select going high; only reset clears it
  always_ff @(negedge link_sclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cmd_q <= 16'h0000;
      done_tgl_q <= 1'b0;
    end
    else if (frame_end)
    begin
      cmd_q <= shift_in_d[15:0];
      done_tgl_q <= ~done_tgl_q;
    end
  end

  // Response word: optional status header, then read-back byte
  assign out_word = len_sel_link[1] ? {snap_status_q, snap_data_q, 24'h000000}
                                    : {snap_data_q, 32'h00000000};

  // Output shifting on the rising shift clock edge
  always_ff @(posedge link_sclk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      sdo_o <= 1'b0;
      shift_out_q <= 40'h0;
    end
    else if (bit_cnt_q == 6'h00)
    begin
      sdo_o <= out_word[39];
      shift_out_q <= {out_word[38:0], 1'b0};
    end
    else
    begin
      sdo_o <= shift_out_q[39];
      shift_out_q <= {shift_out_q[38:0], 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // System domain: crossings and strap capture
  // ---------------------------------------------------------------
  logic cs_n_sync;
  logic done_sync;
  logic [2:0] supply_sync;
  logic done_prev_q;
  logic [1:0] strap_cnt_q;
  logic strap_take;
  logic soft_rst;

  asf_sync #(.WIDTH(1), .RESET_VALUE(1'b1)) u_sync_cs (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(cs_n_i),
    .q_o(cs_n_sync)
  );

  asf_sync #(.WIDTH(4), .RESET_VALUE(4'h0)) u_sync_sys (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({done_tgl_q, analog_low_i, io_brownout_i, regulator_fault_i}),
    .q_o({done_sync, supply_sync})
  );

  // Strap is taken once the chip select synchroniser has filled
  assign strap_take = (strap_cnt_q == asf_pkg::STRAP_WAIT_CYCLES - 2'h1);

  // Wire mode: caught after reset, cleared by chip select high
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      strap_cnt_q <= 2'h0;
      wire3_q <= 1'b0;
    end
    else if (soft_rst)
    begin
      strap_cnt_q <= 2'h0;
      wire3_q <= 1'b0;
    end
    else
    begin
      if (strap_cnt_q != asf_pkg::STRAP_WAIT_CYCLES)
        strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_take)
        wire3_q <= ~cs_n_sync;
      else if (cs_n_sync)
        wire3_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic cmd_vld;
  logic [2:0] opc;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic is_wr;
  logic is_rd;
  logic wr_ok;
  logic wr_status;
  logic wr_cfg;
  logic in_restart;
  logic if_err_q;
  logic start_req;
  logic stop_req;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;

  // Command word is stable for a whole frame after the toggle arrives
  assign cmd_vld = done_sync ^ done_prev_q;
  assign opc = cmd_q[15:13];
  assign addr = cmd_q[11:8];
  assign wdata = cmd_q[7:0];
  assign is_wr = cmd_vld & (opc == asf_pkg::OPC_WRITE);
  assign is_rd = cmd_vld & (opc == asf_pkg::OPC_READ);
  // Interface check error locks every write except to the status register
  assign wr_ok = is_wr & (~if_err_q | (addr == asf_pkg::ADDR_STATUS_FLAGS));
  assign wr_status = wr_ok & (addr == asf_pkg::ADDR_STATUS_FLAGS);
  assign in_restart = (addr >= asf_pkg::ADDR_RESTART_FIRST) &
                      (addr <= asf_pkg::ADDR_RESTART_LAST);
  assign wr_cfg = wr_ok & (addr >= asf_pkg::ADDR_INPUT_SELECT);
  assign soft_rst = wr_ok & (addr == asf_pkg::ADDR_CONVERSION_COMMAND) &
                    (wdata[7:2] == asf_pkg::DEVICE_RESET_CODE) &
                    (wdata[1:0] == 2'b00);
  // Start and stop together do nothing
  assign start_req = wr_ok & (addr == asf_pkg::ADDR_CONVERSION_COMMAND) &
                     wdata[asf_pkg::CMD_START_BIT] & ~wdata[asf_pkg::CMD_STOP_BIT];
  assign stop_req = wr_ok & (addr == asf_pkg::ADDR_CONVERSION_COMMAND) &
                    wdata[asf_pkg::CMD_STOP_BIT] & ~wdata[asf_pkg::CMD_START_BIT];

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  logic uv_q;
  logic por_q;
  logic map_err_q;
  logic uv_clr;
  logic por_clr;
  logic if_clr;
  logic map_clr;

  assign uv_clr = wr_status & wdata[asf_pkg::ST_ANALOG_UV];
  assign por_clr = wr_status & wdata[asf_pkg::ST_POWER_ON];
  assign if_clr = wr_status & wdata[asf_pkg::ST_IF_CHECK_ERR];
  assign map_clr = wr_status & wdata[asf_pkg::ST_MAP_CHECK_ERR];

  // Sticky flags; a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      uv_q <= 1'b1;
      por_q <= 1'b1;
      if_err_q <= 1'b0;
      map_err_q <= 1'b0;
    end
    else
    begin
      uv_q <= supply_sync[2] | (uv_q & ~uv_clr);
      por_q <= soft_rst | supply_sync[1] | supply_sync[0] | (por_q & ~por_clr);
      if_err_q <= ~soft_rst & (if_check_err_i | (if_err_q & ~if_clr));
      map_err_q <= ~soft_rst & (map_check_err_i | (map_err_q & ~map_clr));
    end
  end

  // Wire indicator, sticky flags and live converter state
  assign status_byte = {wire3_q, uv_q, por_q, if_err_q, map_err_q,
                        conv_err_i, modulator_saturation_flag_i, conversion_ready_i};

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0] cfg_q [asf_pkg::ADDR_INPUT_SELECT:asf_pkg::ADDR_REGISTER_MAP_CHECK];

  // Writable registers; a device reset reloads defaults
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = asf_pkg::ADDR_INPUT_SELECT; i <= asf_pkg::ADDR_REGISTER_MAP_CHECK; i++)
        cfg_q[i] <= cfg_reset(4'(i));
    end
    else if (soft_rst)
    begin
      for (int i = asf_pkg::ADDR_INPUT_SELECT; i <= asf_pkg::ADDR_REGISTER_MAP_CHECK; i++)
        cfg_q[i] <= cfg_reset(4'(i));
    end
    else if (wr_cfg)
      cfg_q[addr] <= wdata;
  end

  // Read mux; identity and revision are fixed sources
  assign rd_byte = (addr == asf_pkg::ADDR_DEVICE_IDENTITY) ? asf_pkg::DEVICE_IDENTITY_VALUE :
                   (addr == asf_pkg::ADDR_DIE_REVISION) ? die_revision_i :
                   (addr == asf_pkg::ADDR_STATUS_FLAGS) ? status_byte :
                   (addr == asf_pkg::ADDR_CONVERSION_COMMAND) ? 8'h00 :
                   cfg_q[addr];

  // ---------------------------------------------------------------
  // Answers and converter controls
  // ---------------------------------------------------------------

  // Snapshot for the next frame, taken only at frame completion
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      done_prev_q <= 1'b0;
      snap_status_q <= 8'h00;
      snap_data_q <= 8'h00;
    end
    else
    begin
      done_prev_q <= done_sync;
      if (cmd_vld)
      begin
        snap_status_q <= status_byte;
        snap_data_q <= is_rd ? rd_byte : 8'h00;
      end
    end
  end

  // Registered one-cycle pulses to the converter, plus the registered sdo_oe_o level
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      conv_start_o <= 1'b0;
      conv_stop_o <= 1'b0;
      conv_restart_o <= 1'b0;
      sync_lost_o <= 1'b0;
      device_reset_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end
    else
    begin
      conv_start_o <= start_req;
      conv_stop_o <= stop_req;
      conv_restart_o <= wr_ok & in_restart & converting_i;
      sync_lost_o <= wr_ok & in_restart;
      device_reset_o <= soft_rst;
      sdo_oe_o <= ~cs_n_sync | wire3_q;
    end
  end

  // Configuration outputs come straight from the register array
  assign input_select_o = cfg_q[asf_pkg::ADDR_INPUT_SELECT];
  assign analog_config_o = cfg_q[asf_pkg::ADDR_ANALOG_CONFIG];
  assign conversion_config_o = cfg_q[asf_pkg::ADDR_CONVERSION_CONFIG];
  assign filter_config_o = cfg_q[asf_pkg::ADDR_FILTER_CONFIG];
  assign interface_config_o = cfg_q[asf_pkg::ADDR_INTERFACE_CONFIG];
  assign offset_cal_o = {cfg_q[asf_pkg::ADDR_OFFSET_CAL_HIGH],
                         cfg_q[asf_pkg::ADDR_OFFSET_CAL_MID],
                         cfg_q[asf_pkg::ADDR_OFFSET_CAL_LOW]};
  assign gain_cal_o = {cfg_q[asf_pkg::ADDR_GAIN_CAL_HIGH],
                       cfg_q[asf_pkg::ADDR_GAIN_CAL_MID],
                       cfg_q[asf_pkg::ADDR_GAIN_CAL_LOW]};

endmodule

`default_nettype wire

// File: test/asf_spi_framing_props.sv
// Concurrent checks on the serial framing block's outputs.
// Assumes one system clock domain and the asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module asf_spi_framing_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic converting_i,
  input wire logic sdo_oe_o,
  input wire logic conv_start_o,
  input wire logic conv_stop_o,
  input wire logic conv_restart_o,
  input wire logic sync_lost_o,
  input wire logic device_reset_o,
  input wire logic [7:0] input_select_o,
  input wire logic [7:0] analog_config_o,
  input wire logic [23:0] gain_cal_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Command pulses, at most one at a time; a restart always comes with a sync loss
  a_one_access: assert property ($onehot0({conv_start_o, conv_stop_o, device_reset_o, sync_lost_o}))
    else $error("several command pulses at once");
  a_restart_sync: assert property (conv_restart_o |-> sync_lost_o)
    else $error("restart without sync loss");
  a_idle_stays: assert property (conv_restart_o |-> $past(converting_i))
    else $error("restart while converter idle");
  a_sync_single: assert property (sync_lost_o |=> !sync_lost_o [*8])
    else $error("sync loss pulse too long");
  // Soft reset reloads the configuration defaults
  a_reset_reload: assert property (device_reset_o |-> ##[0:3]
    (gain_cal_o == 24'h400000 && analog_config_o == 8'h00))
    else $error("soft reset did not reload configuration");
  a_cfg_cause: assert property ($changed({input_select_o, analog_config_o, gain_cal_o})
    && !$past(device_reset_o) && !$past(device_reset_o, 2) && !$past(device_reset_o, 3)
    |-> ##[0:1] (sync_lost_o || device_reset_o))
    else $error("configuration changed without sync loss");
  // Output enable follows chip select and wire mode
  a_cs_high_oe: assert property (cs_n_i [*6] |-> !sdo_oe_o)
    else $error("output driven with chip select high");
  a_cs_low_oe: assert property (!cs_n_i [*6] |-> sdo_oe_o)
    else $error("output not driven while selected");
endmodule

bind asf_spi_framing asf_spi_framing_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .cs_n_i(cs_n_i), .converting_i(converting_i), .sdo_oe_o(sdo_oe_o),
  .conv_start_o(conv_start_o), .conv_stop_o(conv_stop_o), .conv_restart_o(conv_restart_o),
  .sync_lost_o(sync_lost_o), .device_reset_o(device_reset_o),
  .input_select_o(input_select_o), .analog_config_o(analog_config_o),
  .gain_cal_o(gain_cal_o));

`default_nettype wire

// File: test/asf_host.sv
// Host controller model that shifts frames over the serial link.
// Assumes the device samples data on falling shift clock edges.
`timescale 1ns/1ns
`default_nettype none

module asf_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  // Clock stands still low between frames, no stray edges
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    sdi_o = 1'b1;
  end

  // One frame MSB first, clock count equal to the frame length
  task automatic xfer(input logic [31:0] tx, input int n, input bit four,
                      output logic [31:0] rx);
    rx = '0;
    if (four)
    begin
      cs_n_o = 1'b1;
      #100 cs_n_o = 1'b0;
    end
    for (int i = n - 1; i >= 0; i--)
    begin
      #20 sdi_o = tx[i];
      #20 sclk_o = 1'b1;
      #40 rx = {rx[30:0], sdo_i};
      sclk_o = 1'b0;
    end
    #20 sdi_o = ~tx[0]; // Released line shows the inverse
    if (four)
      cs_n_o = 1'b1;
    #80;
  endtask
endmodule

`default_nettype wire

// File: test/tb_asf_spi_framing.sv
// Self-checking bench for the serial framing block and register map.
// Assumes the host model on the link and a 100 MHz system clock.
`timescale 1ns/1ns
`default_nettype none

module tb_asf_spi_framing;
  logic clk, rst_n, sclk, cs_n, sdi, sdo, sdo_oe, conv, start, stop, restart, sync, devrst;
  logic [7:0] rev, c_is, c_an, c_cv, c_fl, c_if, d;
  logic [23:0] offs, gain;
  logic [4:0] ev, f;
  logic [2:0] lv;
  logic [31:0] rx;
  logic [7:0] mem [4:14];
  int seed = 91, n_fail = 0, compares = 0, n_sync = 0, n_rs = 0, n_dev = 0, nb = 24;
  int n_st = 0, n_sp = 0;
  int s0, r0, d0;
  int fb [5] = '{3, 2, 2, 1, 0};
  bit four = 0;
  localparam logic [2:0] W = asf_pkg::OPC_WRITE;

  asf_host host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));
  asf_spi_framing uut (.clk_i(clk), .rst_n_i(rst_n), .link_sclk_i(sclk), .cs_n_i(cs_n),
    .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .die_revision_i(rev),
    .analog_low_i(ev[0]), .io_brownout_i(ev[1]), .regulator_fault_i(ev[2]),
    .if_check_err_i(ev[3]), .map_check_err_i(ev[4]), .conv_err_i(lv[2]),
    .modulator_saturation_flag_i(lv[1]), .conversion_ready_i(lv[0]), .converting_i(conv),
    .conv_start_o(start), .conv_stop_o(stop), .conv_restart_o(restart),
    .sync_lost_o(sync), .device_reset_o(devrst), .input_select_o(c_is),
    .analog_config_o(c_an), .conversion_config_o(c_cv), .filter_config_o(c_fl),
    .interface_config_o(c_if), .offset_cal_o(offs), .gain_cal_o(gain));

  // System clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Count command pulses
  always @(posedge clk)
  begin
    if (sync === 1'b1) n_sync++;
    if (restart === 1'b1) n_rs++;
    if (devrst === 1'b1) n_dev++;
    if (start === 1'b1) n_st++;
    if (stop === 1'b1) n_sp++;
  end

  function automatic logic [31:0] cmd(input logic [2:0] op, input logic [3:0] a,
                                      input logic [7:0] v);
    return {16'h0, op, 1'b0, a, v};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic acc(input logic [2:0] op, input logic [3:0] a, input logic [7:0] v);
    host.xfer(cmd(op, a, v), nb, four, rx);
  endtask

  // Read frame, then an idle frame that returns the byte
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    acc(asf_pkg::OPC_READ, a, 8'h00);
    acc(3'h0, 4'h0, 8'h00);
    chk(rx[23:16], exp);
  endtask

  // Hold one status event for a few clocks
  task automatic pulse(input int k);
    @(posedge clk) ev[k] <= 1'b1;
    repeat (3) @(posedge clk);
    ev[k] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic final_report;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog against a hung link
  initial
  begin
    #600000;
    n_fail++;
    final_report;
  end

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    conv = 1'b0;
    ev = '0;
    lv = 3'($random(seed));
    rev = 8'($random(seed));
    f = 5'b11100;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(asf_pkg::ADDR_STATUS_FLAGS, {f, lv});
    rd(asf_pkg::ADDR_DEVICE_IDENTITY, asf_pkg::DEVICE_IDENTITY_VALUE);
    acc(W, asf_pkg::ADDR_DIE_REVISION, ~rev);
    rd(asf_pkg::ADDR_DIE_REVISION, rev);
    for (int k = 0; k < 5; k++)
    begin
      acc(W, 4'h2, 8'hf8);
      f = 5'b10000;
      pulse(k);
      f[fb[k]] = 1'b1;
      rd(4'h2, {f, lv});
      rd(4'h2, {f, lv});
    end
    acc(W, 4'h2, 8'hf8);
    for (int a = 4; a <= 14; a++)
    begin
      d = 8'($random(seed));
      if (a == 8) d = d & 8'hfa;
      @(posedge clk) conv <= d[0];
      mem[a] = d;
      s0 = n_sync;
      r0 = n_rs;
      acc(W, 4'(a), d);
      repeat (8) @(posedge clk);
      chk(8'(n_sync - s0), 8'h01);
      chk(8'(n_rs - r0), {7'h0, d[0]});
      rd(4'(a), d);
    end
    chk(c_an, mem[5]);
    chk(c_cv, mem[6]);
    chk(c_fl, mem[7]);
    chk(c_if, mem[8]);
    chk(offs[15:8], mem[10]);
    chk(gain[23:16], mem[12]);
    host.xfer(32'hffffffff, 5, four, rx);
    host.xfer(32'hffffffff, 32, four, rx);
    host.xfer(32'hffffffff, 31, four, rx);
    host.xfer(32'h0, 1, four, rx);
    rd(4'h5, mem[5]);
    d0 = n_dev;
    s0 = n_st;
    r0 = n_sp;
    acc(W, 4'h3, 8'h5a); // Reset code with start set is only a start
    acc(W, 4'h3, 8'h03);
    acc(W, 4'h3, 8'h01);
    acc(W, 4'h3, {asf_pkg::DEVICE_RESET_CODE, 2'b00});
    repeat (10) @(posedge clk);
    chk(8'(n_dev - d0), 8'h01);
    chk(8'(n_st - s0), 8'h01);
    chk(8'(n_sp - r0), 8'h01);
    chk(gain[23:16], 8'h40);
    rd(4'h5, 8'h00);
    rd(4'h2, {5'b10100, lv});
    chk(rx[23:16] & 8'hb8, 8'ha0);
    pulse(3);
    s0 = n_sync;
    acc(W, 4'h5, 8'h33);
    rd(4'h5, 8'h00);
    chk(8'(n_sync - s0), 8'h00);
    acc(W, 4'h2, 8'h10);
    acc(W, 4'h5, 8'h33);
    rd(4'h5, 8'h33);
    acc(W, 4'h8, 8'h01);
    nb = 32;
    rd(4'h8, 8'h01);
    chk(rx[31:24] & 8'hb8, 8'ha0);
    acc(W, 4'h8, 8'h00);
    nb = 24;
    rd(4'h8, 8'h00);
    four = 1;
    rd(4'h5, 8'h33);
    chk({7'h0, sdo_oe}, 8'h00);
    rd(4'h2, {5'b00100, lv});
    chk(rx[23:16] & 8'h80, 8'h00);
    final_report;
  end
endmodule

`default_nettype wire
